// *** design/swl_port.sv ***
// Purpose: Device end of the single-wire register port with flash commands.
// Assumes: Open-drain line with external pull-up; host keeps its own timing.
// Notes: Flash is modelled as flip-flops that reset to the erased value.
`timescale 1ns/100ps
`include "swl_link_regs.svh"
// How it works
// - Program byte ANDs data into flash
// - Direct banks programmed only byte-wise
// - Codes erase flash pages zero to two
// - Code erases offset shadow flash
// - Code copies RAM page into flash
// - Code copies flash page into RAM
// - Code enters low-power mode
// - Code calibrates integrator and powers down on one clock
// - Page transfer ANDs RAM into flash
// - Command byte, then data in or out
// - Eight-bit bytes, at most 5 kbit/s
// - Bytes travel least-significant bit first
// - Long low is break; recovery then ready
// - Transmitter starts bit with low period
// - Bit level valid by setup, held
// - Release by stop setup, high till cycle
// - Command bit seven selects write or read
// - Low seven bits give register address
module swl_port #(
  parameter int TICK_CYCLES = `SWL_TICK_CYCLES,
  parameter int START_LOW_TICKS = `SWL_START_LOW_TICKS,
  parameter int DATA_SETUP_TICKS = `SWL_DATA_SETUP_TICKS,
  parameter int STOP_SETUP_TICKS = `SWL_STOP_SETUP_TICKS,
  parameter int BIT_CYCLE_TICKS = `SWL_MIN_BIT_TICKS,
  parameter int BREAK_TICKS = `SWL_BREAK_TICKS,
  parameter int BREAK_RECOVERY_TICKS = `SWL_BREAK_RECOVERY_TICKS,
  parameter int BUF_DEPTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic single_wire_line_in,
  output logic single_wire_line_out,
  output logic single_wire_line_oe_out,
  output logic power_down_out,
  output logic calibrate_out,
  output logic overrun_out,
  output swl_pkg::swl_byte_t flash_command_register_out
);
  import swl_pkg::*;

  // Tick counts cut to the counter width
  localparam logic [15:0] T_DIV = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] T_START = 16'(START_LOW_TICKS);
  localparam logic [15:0] T_SETUP = 16'(DATA_SETUP_TICKS);
  localparam logic [15:0] T_STOP = 16'(STOP_SETUP_TICKS);
  localparam logic [15:0] T_CYCLE = 16'(BIT_CYCLE_TICKS);
  localparam logic [15:0] T_BREAK = 16'(BREAK_TICKS);
  localparam logic [15:0] T_RECOV = 16'(BREAK_RECOVERY_TICKS);

  swl_state_s st_r;
  swl_state_s st_nxt;
  logic line;
  logic tick;
  logic samp;
  logic push_valid;
  logic push_ready;
  swl_byte_t push_byte;
  logic pop_valid;
  logic pop_ready;
  swl_byte_t pop_byte;
  logic pop;
  logic cmd_fire;
  logic brk_hit;
  logic prog_fire;
  logic [6:0] prog_idx;
  swl_byte_t prog_old;

  // Synchronised line level and timebase tick
  assign line = st_r.lsync[1];
  assign tick = (st_r.tick_div == T_DIV);

  // Receiver sample point and assembled byte, LSB arrives first
  assign samp = (st_r.link == L_RX) && tick && (st_r.cnt == T_SETUP - 16'h0001);
  assign push_byte = {line, st_r.rx_sh[7:1]};
  assign push_valid = samp && (st_r.rx_bits == 3'h7);
  assign brk_hit = (st_r.link == L_RX) && (st_r.cnt >= T_BREAK);

  // Executor stalls while a read answer is outstanding
  assign pop_ready = !st_r.tx_go;
  assign pop = pop_valid && pop_ready;
  assign cmd_fire = pop && st_r.phase_data && (st_r.wr_addr == `SWL_FLASH_CMD_ADDR);
  assign prog_fire = cmd_fire && (pop_byte == `SWL_CMD_PROG_BYTE);
  assign prog_idx = st_r.flash_program_address[6:0];
  assign prog_old = (prog_idx < `SWL_FLASH_END) ? st_r.flash[prog_idx] :
                    (prog_idx >= `SWL_OFS_BASE && prog_idx < `SWL_OFS_END) ?
                    st_r.shadow[2'(prog_idx - `SWL_OFS_BASE)] : `SWL_ERASED_BYTE;

  swl_pair_buf #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_byte),
    .out_valid_out(pop_valid),
    .out_ready_in(pop_ready),
    .out_data_out(pop_byte)
  );

  // Register read map: RAM, flash banks 1-2, control bytes, offsets
  function automatic swl_byte_t rd_byte(input swl_state_s s, input logic [6:0] a);
    swl_byte_t d;
    d = 8'h00;
    if (a < `SWL_PAGE1_BASE) begin
      d = s.ram[a[4:0]];
    end else if (a < `SWL_FLASH_END) begin
      d = s.flash[a];
    end else if (a == `SWL_FLASH_CMD_ADDR) begin
      d = s.flash_command;
    end else if (a == `SWL_PROG_DATA_ADDR) begin
      d = s.flash_program_data;
    end else if (a == `SWL_PROG_ADDR_ADDR) begin
      d = s.flash_program_address;
    end else if (a >= `SWL_OFS_BASE && a < `SWL_OFS_END) begin
      d = s.ofs[2'(a - `SWL_OFS_BASE)];
    end
    return d;
  endfunction

  // Whole next-state: line handling, executor and flash commands
  always_comb begin
    st_nxt = st_r;
    st_nxt.lsync = {st_r.lsync[0], single_wire_line_in};
    st_nxt.tick_div = tick ? 16'h0000 : st_r.tick_div + 16'h0001;
    st_nxt.cal = 1'b0;
    // Line state machine
    case (st_r.link)
      L_IDLE: begin
        st_nxt.cnt = 16'h0000;
        if (!line) begin
          st_nxt.link = L_RX; // Falling edge opens a bit frame
        end else if (st_r.tx_go) begin
          st_nxt.link = L_TXGAP;
        end
      end
      L_RX: begin
        if (tick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        if (samp) begin
          st_nxt.rx_sh = push_byte;
          st_nxt.rx_bits = st_r.rx_bits + 3'h1;
          if (push_valid && !push_ready) begin
            st_nxt.overrun = 1'b1;
          end
        end
        if (brk_hit) begin
          st_nxt.link = L_BRK_LOW;
        end else if (line && st_r.cnt >= T_SETUP) begin
          st_nxt.link = L_IDLE;
        end
      end
      L_BRK_LOW: begin
        st_nxt.cnt = 16'h0000;
        if (line) begin
          st_nxt.link = L_BRK_REC;
        end
      end
      L_BRK_REC: begin
        if (!line) begin
          st_nxt.link = L_BRK_LOW;
        end else if (tick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (st_r.cnt == T_RECOV - 16'h0001) begin
            st_nxt.link = L_IDLE; // Ready for a command
          end
        end
      end
      L_TXGAP: begin
        if (tick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (st_r.cnt == T_CYCLE - 16'h0001) begin
            st_nxt.link = L_TX;
            st_nxt.cnt = 16'h0000;
          end
        end
      end
      L_TX: begin
        if (tick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (st_r.cnt == T_CYCLE - 16'h0001) begin
            st_nxt.cnt = 16'h0000; // Full bit cycle done, start next bit
            st_nxt.tx_sh = {1'b1, st_r.tx_sh[7:1]};
            st_nxt.tx_bits = st_r.tx_bits + 3'h1;
            if (st_r.tx_bits == 3'h7) begin
              st_nxt.link = L_IDLE;
              st_nxt.tx_go = 1'b0;
            end
          end
        end
      end
      default: begin
        st_nxt.link = L_IDLE;
      end
    endcase
    // Command byte, then data byte or read answer
    if (pop) begin
      if (!st_r.phase_data) begin
        if (pop_byte[7]) begin
          st_nxt.phase_data = 1'b1; // Write direction
          st_nxt.wr_addr = pop_byte[6:0];
        end else begin
          st_nxt.tx_sh = rd_byte(st_r, pop_byte[6:0]); // Read
          st_nxt.tx_bits = 3'h0;
          st_nxt.tx_go = 1'b1;
        end
      end else begin
        st_nxt.phase_data = 1'b0;
        if (st_r.wr_addr < `SWL_PAGE1_BASE) begin
          st_nxt.ram[st_r.wr_addr[4:0]] = pop_byte;
        end else if (st_r.wr_addr == `SWL_FLASH_CMD_ADDR) begin
          st_nxt.flash_command = pop_byte;
        end else if (st_r.wr_addr == `SWL_PROG_DATA_ADDR) begin
          st_nxt.flash_program_data = pop_byte;
        end else if (st_r.wr_addr == `SWL_PROG_ADDR_ADDR) begin
          st_nxt.flash_program_address = pop_byte;
        end else if (st_r.wr_addr >= `SWL_OFS_BASE && st_r.wr_addr < `SWL_OFS_END) begin
          st_nxt.ofs[2'(st_r.wr_addr - `SWL_OFS_BASE)] = pop_byte;
        end
      end
    end
    // Flash command execution
    if (cmd_fire) begin
      case (pop_byte)
        `SWL_CMD_PROG_BYTE: begin
          // One byte per command, data ANDed into old contents
          if (prog_idx < `SWL_FLASH_END) begin
            st_nxt.flash[prog_idx] = prog_old & st_r.flash_program_data;
          end else if (prog_idx >= `SWL_OFS_BASE && prog_idx < `SWL_OFS_END) begin
            st_nxt.shadow[2'(prog_idx - `SWL_OFS_BASE)] = prog_old & st_r.flash_program_data;
          end
        end
        `SWL_CMD_ERASE_P0: st_nxt.flash[31:0] = '1;
        `SWL_CMD_ERASE_P1: st_nxt.flash[63:32] = '1;
        `SWL_CMD_ERASE_P2: st_nxt.flash[95:64] = '1;
        `SWL_CMD_ERASE_OFS: st_nxt.shadow = '1;
        `SWL_CMD_RAM_TO_FL: st_nxt.flash[31:0] = st_r.flash[31:0] & st_r.ram;
        `SWL_CMD_FL_TO_RAM: st_nxt.ram = st_r.flash[31:0];
        `SWL_CMD_POWER_DOWN: st_nxt.pd = 1'b1;
        `SWL_CMD_CAL_PD: begin
          st_nxt.cal = 1'b1; // Calibration pulse and sleep start on the same clock
          st_nxt.pd = 1'b1;
        end
        default: begin
          st_nxt.pd = st_r.pd;
        end
      endcase
    end
    // Break aborts a half-done write or partial byte, not a pending read answer, and wakes the device
    if (brk_hit) begin
      st_nxt.rx_bits = 3'h0;
      st_nxt.phase_data = 1'b0;
      st_nxt.pd = 1'b0;
    end
    // Pull low for start, and on a zero until stop setup
    st_nxt.oe = (st_nxt.link == L_TX) &&
                ((st_nxt.cnt < T_START) || (!st_nxt.tx_sh[0] && st_nxt.cnt < T_STOP));
  end

  // State register; flash and RAM come up erased
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.lsync <= 2'b11;
      st_r.ram <= '1;
      st_r.flash <= '1;
      st_r.ofs <= '1;
      st_r.shadow <= '1;
      st_r.flash_command <= `SWL_CMD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Open-drain line only ever pulls low
  assign single_wire_line_out = 1'b0;
  assign single_wire_line_oe_out = st_r.oe;
  assign power_down_out = st_r.pd;
  assign calibrate_out = st_r.cal;
  assign overrun_out = st_r.overrun;
  assign flash_command_register_out = st_r.flash_command;

  a_prog_and_byte: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (prog_fire && prog_idx < `SWL_FLASH_END) |=>
    st_r.flash[$past(prog_idx)] == ($past(prog_old) & $past(st_r.flash_program_data)))
    else $error("program byte did not AND data into flash");
  a_erase_page_one: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cmd_fire && pop_byte == `SWL_CMD_ERASE_P1) |=> (&st_r.flash[63:32]))
    else $error("page one not erased");
  a_erase_shadow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cmd_fire && pop_byte == `SWL_CMD_ERASE_OFS) |=> (&st_r.shadow))
    else $error("offset shadow not erased");
  a_ram_to_flash: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cmd_fire && pop_byte == `SWL_CMD_RAM_TO_FL) |=>
    st_r.flash[31:0] == ($past(st_r.flash[31:0]) & $past(st_r.ram)))
    else $error("page transfer to flash wrong");
  a_flash_to_ram: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cmd_fire && pop_byte == `SWL_CMD_FL_TO_RAM) |=> st_r.ram == $past(st_r.flash[31:0]))
    else $error("page transfer to RAM wrong");
  a_cal_then_sleep: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cmd_fire && pop_byte == `SWL_CMD_CAL_PD && !brk_hit) |=>
    (calibrate_out && power_down_out) ##1 !calibrate_out)
    else $error("calibration pulse or power down missing");
  a_sleep_cmd: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cmd_fire && pop_byte == `SWL_CMD_POWER_DOWN && !brk_hit) |=> power_down_out)
    else $error("power down not entered");
  a_cmd_decode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pop && !st_r.phase_data && pop_byte[7] && !brk_hit) |=>
    (st_r.phase_data && st_r.wr_addr == $past(pop_byte[6:0]) && !st_r.tx_go))
    else $error("write command not decoded");
  a_read_answer: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pop && !st_r.phase_data && !pop_byte[7]) |=>
    (st_r.tx_go && st_r.tx_sh == rd_byte($past(st_r), $past(pop_byte[6:0]))))
    else $error("read answer not loaded");
  a_break_seen: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    brk_hit |=> (st_r.link == L_BRK_LOW && !st_r.phase_data && st_r.rx_bits == 3'h0))
    else $error("break not recognised");
  a_start_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (st_r.link == L_TX && st_r.cnt < T_START && !$rose(st_r.link == L_TX)) |->
    single_wire_line_oe_out) else $error("start low not driven");
  a_stop_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (st_r.link == L_TX && st_r.cnt > T_STOP) |-> !single_wire_line_oe_out)
    else $error("line not released by stop setup");
  a_idle_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (st_r.link != L_TX) |-> !single_wire_line_oe_out)
    else $error("line driven outside a sent bit");
endmodule // swl_port

// *** design/swl_link_regs.svh ***
// Purpose: Constants for the single-wire register port: offsets, codes, timing.
// Assumes: 200 MHz system clock; internal timebase tick of 1 us.
// Notes: Bit timings are in timebase ticks; defaults are plain working values.
`ifndef SWL_LINK_REGS_SVH
`define SWL_LINK_REGS_SVH

// Register offsets on the single wire
`define SWL_PAGE1_BASE 7'h20
`define SWL_PAGE2_BASE 7'h40
`define SWL_FLASH_END 7'h60
`define SWL_FLASH_CMD_ADDR 7'h62
`define SWL_PROG_DATA_ADDR 7'h6f
`define SWL_PROG_ADDR_ADDR 7'h70
`define SWL_OFS_BASE 7'h75
`define SWL_OFS_END 7'h78

// Flash command codes
`define SWL_CMD_PROG_BYTE 8'h0f
`define SWL_CMD_ERASE_P0 8'h40
`define SWL_CMD_ERASE_P1 8'h41
`define SWL_CMD_ERASE_P2 8'h42
`define SWL_CMD_ERASE_OFS 8'h43
`define SWL_CMD_RAM_TO_FL 8'h45
`define SWL_CMD_FL_TO_RAM 8'h48
`define SWL_CMD_POWER_DOWN 8'hf6
`define SWL_CMD_CAL_PD 8'hf7

// Reset values
`define SWL_ERASED_BYTE 8'hff
`define SWL_CMD_RESET 8'h00

// Timing: clock, timebase and the fastest allowed bit rate
`define SWL_CLK_PERIOD_NS 5
`define SWL_TICK_NS 1000
`define SWL_TICK_CYCLES (`SWL_TICK_NS / `SWL_CLK_PERIOD_NS)
`define SWL_MAX_RATE_BPS 5000
`define SWL_MIN_BIT_NS (1000000000 / `SWL_MAX_RATE_BPS)
`define SWL_MIN_BIT_TICKS ((`SWL_MIN_BIT_NS + `SWL_TICK_NS - 1) / `SWL_TICK_NS)
`define SWL_START_LOW_TICKS 40
`define SWL_DATA_SETUP_TICKS 100
`define SWL_STOP_SETUP_TICKS 160
`define SWL_BREAK_TICKS 190
`define SWL_BREAK_RECOVERY_TICKS 40

`endif

// *** design/swl_pkg.sv ***
// Purpose: Types shared by the single-wire register port.
// Assumes: Widths fixed by the register space (128 byte addresses).
// Notes: All state of the main module lives in one packed struct.
package swl_pkg;

  // Line handling states
  typedef enum logic [2:0] {
    L_IDLE    = 3'b000,
    L_RX      = 3'b001,
    L_BRK_LOW = 3'b010,
    L_BRK_REC = 3'b011,
    L_TXGAP   = 3'b100,
    L_TX      = 3'b101
  } swl_link_e;

  typedef logic [7:0] swl_byte_t;

  typedef struct packed {
    logic [1:0] lsync;
    swl_link_e link;
    logic [15:0] tick_div;
    logic [15:0] cnt;
    swl_byte_t rx_sh;
    logic [2:0] rx_bits;
    swl_byte_t tx_sh;
    logic [2:0] tx_bits;
    logic tx_go;
    logic phase_data;
    logic [6:0] wr_addr;
    logic [31:0][7:0] ram;
    logic [95:0][7:0] flash;
    logic [2:0][7:0] ofs;
    logic [2:0][7:0] shadow;
    swl_byte_t flash_program_data;
    swl_byte_t flash_program_address;
    swl_byte_t flash_command;
    logic pd;
    logic cal;
    logic oe;
    logic overrun;
  } swl_state_s;

endpackage

// *** design/swl_pair_buf.sv ***
// Purpose: Small valid/ready buffer between the bit receiver and the executor.
// Assumes: Same clock on both sides.
// Notes: in_ready_out drops when full so the receiver sees back-pressure.
`timescale 1ns/100ps
`include "swl_link_regs.svh"
module swl_pair_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } swl_buf_s;

  swl_buf_s st_r;
  swl_buf_s st_nxt;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid_out = (st_r.count != '0);
  assign out_data_out = st_r.mem[st_r.rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and storage update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_in;
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_buf_no_overfill: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.count <= (AW+1)'(DEPTH)) else $error("buffer count above depth");
  a_buf_full_stall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (push && !pop && st_r.count == (AW+1)'(DEPTH - 1)) |=> !in_ready_out)
    else $error("buffer not stalling when full");
endmodule // swl_pair_buf

// *** verif/swl_host_model.sv ***
// Purpose: Host end of the single-wire link, used by the bench.
// Assumes: Open-drain wire that floats high when no one pulls.
// Notes: Times are in ticks of TICK clocks; gap_min logs frame spacing.
`timescale 1ns/100ps
`include "swl_link_regs.svh"
module swl_host_model #(
  parameter int TICK = 2,
  parameter int T_START = 2,
  parameter int T_SETUP = 4,
  parameter int T_STOP = 6,
  parameter int T_CYC = 12,
  // Break and recovery stretched past the device's own counts for margin
  parameter int T_BRK = `SWL_BREAK_TICKS + 10,
  parameter int T_REC = `SWL_BREAK_RECOVERY_TICKS + 2
) (
  input wire logic sys_clk_in,
  input wire logic wire_in,
  output logic pull_out
);
  int gap_min;
  int cyc;
  initial pull_out = 1'b0;
  initial gap_min = 9999;
  initial cyc = 0;
  // Free-running cycle count for spacing
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  // Wait whole ticks, leave just after an edge
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge sys_clk_in);
    #1;
  endtask
  // One frame: start low, level, release, high rest
  task automatic send_bit(input logic b);
    pull_out = 1'b1;
    ticks(T_START);
    pull_out = ~b;
    ticks(T_STOP - T_START);
    pull_out = 1'b0;
    ticks(T_CYC - T_STOP);
  endtask
  // Whole byte, low bit first
  task automatic send_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      send_bit(d[i]);
    end
  endtask
  // Long low, then high for recovery
  task automatic send_break();
    pull_out = 1'b1;
    ticks(T_BRK);
    pull_out = 1'b0;
    ticks(T_REC);
  endtask
  // Take eight device frames, low bit first
  task automatic recv_byte(output logic [7:0] d, output logic ok);
    int n;
    int last;
    ok = 1'b1;
    last = -1;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (wire_in !== 1'b0 && n < 60 * T_CYC * TICK) begin
        @(posedge sys_clk_in);
        n++;
      end
      if (n >= 60 * T_CYC * TICK) ok = 1'b0;
      if (last >= 0 && cyc - last < gap_min) gap_min = cyc - last;
      last = cyc;
      @(posedge sys_clk_in);
      if (wire_in !== 1'b0) ok = 1'b0;
      repeat (T_SETUP * TICK - 1) @(posedge sys_clk_in);
      d[i] = wire_in;
      n = 0;
      while (wire_in !== 1'b1 && n < T_CYC * TICK) begin
        @(posedge sys_clk_in);
        n++;
      end
    end
    #1;
  endtask
endmodule // swl_host_model

// *** verif/single_wire_host_register_port_tb.sv ***
// Purpose: Self-checking bench for the single-wire register port.
// Assumes: Short tick and bit timings so the run stays brief.
// Notes: Wire level is worked out from both pull-downs and a pull-up.
`timescale 1ns/100ps
`include "swl_link_regs.svh"
module single_wire_host_register_port_tb;
  import swl_pkg::*;
  logic sys_clk;
  logic rst;
  logic host_pull;
  logic line;
  logic oe;
  logic dout;
  logic pd;
  logic cal;
  logic ovr;
  logic ok;
  swl_byte_t flash_command;
  swl_byte_t d;
  swl_byte_t d2;
  swl_byte_t got;
  logic [6:0] a;
  int num_errors;
  int tests_run;
  int seed;
  int cyc;
  int cal_cnt;
  // Open drain with pull-up
  assign line = ~host_pull & (oe ? dout : 1'b1);
  // Short bit timings; break, recovery and buffer depth keep their defaults
  swl_port #(.TICK_CYCLES(2), .START_LOW_TICKS(2), .DATA_SETUP_TICKS(4),
    .STOP_SETUP_TICKS(6), .BIT_CYCLE_TICKS(10)) DUT (
    .sys_clk_in(sys_clk), .rst_in(rst), .single_wire_line_in(line),
    .single_wire_line_out(dout), .single_wire_line_oe_out(oe),
    .power_down_out(pd), .calibrate_out(cal), .overrun_out(ovr),
    .flash_command_register_out(flash_command));
  swl_host_model host (.sys_clk_in(sys_clk), .wire_in(line), .pull_out(host_pull));
  // Clock and cycle ceiling
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cal === 1'b1) cal_cnt <= cal_cnt + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  // Compare one value, count and report
  task automatic check(input string nm, input swl_byte_t seen, input swl_byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Program and transfer both AND into flash
  function automatic swl_byte_t and_exp(swl_byte_t old, swl_byte_t nw);
    return old & nw;
  endfunction
  task automatic wr(input logic [6:0] ad, input swl_byte_t v);
    host.send_byte({1'b1, ad});
    host.send_byte(v);
  endtask
  task automatic rd(input logic [6:0] ad, output swl_byte_t v);
    host.send_byte({1'b0, ad});
    host.recv_byte(v, ok);
    check("answer", {7'h0, ok}, 8'h01);
    host.ticks(12);
  endtask
  task automatic cmd(input swl_byte_t c);
    wr(`SWL_FLASH_CMD_ADDR, c);
  endtask
  initial begin
    num_errors = 0;
    tests_run = 0;
    seed = 57;
    rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    check("flash_command rst", flash_command, `SWL_CMD_RESET);
    check("flags rst", {5'h0, pd, ovr, oe}, 8'h00);
    host.send_break();
    // RAM at both ends and at random places
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? 7'(i * 31) : 7'($random(seed) & 31);
      d = 8'($random(seed));
      wr(a, d);
      rd(a, got);
      check("ram", got, d);
    end
    // Direct flash is read only; unmapped reads zero
    wr(7'h30, 8'h00);
    rd(7'h30, got);
    check("flash ro", got, 8'hff);
    rd(7'h71, got);
    check("unmapped", got, 8'h00);
    // Byte program three times, pages 1 and 2, then erase each
    d = 8'($random(seed));
    d2 = 8'($random(seed));
    wr(`SWL_PROG_DATA_ADDR, d);
    wr(`SWL_PROG_ADDR_ADDR, 8'h25);
    cmd(`SWL_CMD_PROG_BYTE);
    wr(`SWL_PROG_ADDR_ADDR, 8'h45);
    cmd(`SWL_CMD_PROG_BYTE);
    wr(`SWL_PROG_DATA_ADDR, d2);
    cmd(`SWL_CMD_PROG_BYTE);
    rd(7'h25, got);
    check("prog p1", got, and_exp(8'hff, d));
    rd(7'h45, got);
    check("prog p2", got, and_exp(d, d2));
    cmd(`SWL_CMD_ERASE_P1);
    rd(7'h25, got);
    check("erase p1", got, 8'hff);
    rd(7'h45, got);
    check("p2 kept", got, and_exp(d, d2));
    cmd(`SWL_CMD_ERASE_P2);
    rd(7'h45, got);
    check("erase p2", got, 8'hff);
    // Page 0 transfers both ways, then erase
    wr(7'h03, d);
    cmd(`SWL_CMD_RAM_TO_FL);
    wr(7'h03, d2);
    cmd(`SWL_CMD_FL_TO_RAM);
    rd(7'h03, got);
    check("ram to flash", got, d);
    wr(7'h03, d2);
    cmd(`SWL_CMD_RAM_TO_FL);
    cmd(`SWL_CMD_FL_TO_RAM);
    rd(7'h03, got);
    check("and transfer", got, and_exp(d, d2));
    cmd(`SWL_CMD_ERASE_P0);
    cmd(`SWL_CMD_FL_TO_RAM);
    rd(7'h03, got);
    check("erase p0", got, 8'hff);
    // Offset byte and its shadow erase
    wr(`SWL_OFS_BASE, d);
    rd(`SWL_OFS_BASE, got);
    check("offset", got, d);
    cmd(`SWL_CMD_ERASE_OFS);
    rd(`SWL_FLASH_CMD_ADDR, got);
    check("cmd reg", got, `SWL_CMD_ERASE_OFS);
    check("cmd port", flash_command, `SWL_CMD_ERASE_OFS);
    // Low power, break wakes, then calibrate
    cmd(`SWL_CMD_POWER_DOWN);
    check("pd", {6'h0, cal_cnt[0], pd}, 8'h01);
    host.send_break();
    check("pd break", {7'h0, pd}, 8'h00);
    cmd(`SWL_CMD_CAL_PD);
    check("cal", {6'h0, 1'(cal_cnt == 1), pd}, 8'h03);
    // Reset in mid-run clears power down and the command register
    rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    check("flash_command mid rst", flash_command, `SWL_CMD_RESET);
    check("flags mid rst", {5'h0, pd, ovr, oe}, 8'h00);
    // Break in mid-byte drops the partial command
    host.send_bit(1'b1);
    host.send_bit(1'b0);
    host.send_bit(1'b1);
    host.send_break();
    rd(7'h00, got);
    check("after break", got, `SWL_ERASED_BYTE);
    check("pd after break", {7'h0, pd}, 8'h00);
    // Answer frames start exactly one bit cycle (10 ticks of 2 clocks) apart
    check("spacing", {7'h0, 1'(host.gap_min == 20)}, 8'h01);
    check("overrun", {7'h0, ovr}, 8'h00);
    report_and_stop();
  end
endmodule // single_wire_host_register_port_tb
